// File: bus_word_src.sv
// Model of the monitored serial bus as seen through the word decoder.
`timescale 1ns/1ps
module bus_word_src (
  // Clock.
  input wire logic clk_sys_i,
  // Decoder events.
  output logic sync2_o,
  output logic word_o,
  output logic is_cmd_o,
  output logic word_ok_o
);
  logic busy_r = 1'b0;
  logic cmd_r = 1'b0;
  logic ok_r = 1'b0;
  logic idle_pat_r = 1'b0;
  initial begin
    sync2_o = 1'b0;
    word_o = 1'b0;
  end
  // Qualifiers carry a changing pattern outside a word so stale values are never trusted.
  always @(posedge clk_sys_i) begin
    idle_pat_r <= ~idle_pat_r;
  end
  assign is_cmd_o = busy_r ? cmd_r : idle_pat_r;
  assign word_ok_o = busy_r ? ok_r : ~idle_pat_r;
  task automatic send(input logic cmd, input logic ok, input logic full);
    @(negedge clk_sys_i);
    busy_r = 1'b1;
    cmd_r = cmd;
    ok_r = ok;
    sync2_o = 1'b1;
    @(negedge clk_sys_i);
    sync2_o = 1'b0;
    if (full) begin
      repeat (2) @(negedge clk_sys_i);
      word_o = 1'b1;
      @(negedge clk_sys_i);
      word_o = 1'b0;
    end
    busy_r = 1'b0;
  endtask : send
endmodule : bus_word_src

// File: pkt_mon_ctrl.sv
// Packet-recording monitor control: packet timer mode and start-record qualification.
//
// Function
// - Freerun 0: packet timer is cleared and held when the monitor is enabled.
// - Freerun 0: timer starts counting at the first qualifying word of a message.
// - Freerun 1 at enable: timer clears and starts counting at once.
// - Freerun 1: at packet finalize, timer clears, restarts, new packet begins.
// - Packet done interrupt is raised at packet completion when enabled.
// - Select 00: start on valid command sync word with 16 bits and odd parity.
// - Select 01: start on any valid complete word, command or data sync.
// - Message started on data sync sets sync error in block status.
// - Select 10: start on command sync plus two bits, fragments included.
// - Select 10: trigger not a valid command word sets invalid word error.
// - Select 11: start on any sync plus two bits, fragments included.
// - Select 11: trigger not a valid word sets invalid word error.
// - Behaviour applies only when monitor type select is 0.
`timescale 1ns/1ps
module pkt_mon_ctrl
  import pkt_mon_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Configuration register port.
  input wire logic cfg_we_i,
  input wire logic [15:0] cfg_wdata_i,
  output logic [15:0] cfg_rdata_o,
  // Monitor enable and interrupt enable.
  input wire logic mon_en_i,
  input wire logic irq_en_i,
  // Word decoder events (same clock domain).
  input wire logic sync2_i,
  input wire logic word_i,
  input wire logic is_cmd_i,
  input wire logic word_ok_i,
  input wire logic msg_end_i,
  // Packet finalize request.
  input wire logic pkt_final_i,
  // Outputs.
  output logic [31:0] pkt_timer_o,
  output logic timer_run_o,
  output logic recording_o,
  output logic msg_start_o,
  output logic sync_err_o,
  output logic inv_err_o,
  output logic packet_done_irq_o
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [15:0] cfg;
    mon_state_t st;
    logic en_d;
    logic [`PKT_TIMER_W-1:0] tmr;
    logic run;
    logic start;
    logic serr;
    logic ierr;
    logic irq;
  } ctrl_t;

  ctrl_t cur_r;
  ctrl_t cur_nxt;
  logic q_start;
  logic q_serr;
  logic q_ierr;
  logic active;
  logic freerun;

  assign freerun = cur_r.cfg[`CFG_BIT_FREERUN];
  assign active = mon_en_i && !cur_r.cfg[`CFG_BIT_TYPE_SEL];

  start_qual u_qual (
    .sel_i(cur_r.cfg[`CFG_BIT_SRS_HI:`CFG_BIT_SRS_LO]),
    .sync2_i(sync2_i),
    .word_i(word_i),
    .is_cmd_i(is_cmd_i),
    .word_ok_i(word_ok_i),
    .start_o(q_start),
    .sync_err_o(q_serr),
    .inv_err_o(q_ierr)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.start = 1'b0;
    cur_nxt.serr = 1'b0;
    cur_nxt.ierr = 1'b0;
    cur_nxt.irq = 1'b0;
    cur_nxt.en_d = active;
    if (cfg_we_i) begin
      cur_nxt.cfg = cfg_wdata_i;
    end
    if (cur_r.run) begin
      cur_nxt.tmr = cur_r.tmr + `PKT_TIMER_ONE;
    end
    if (!active) begin
      cur_nxt.st = ST_OFF;
      cur_nxt.run = 1'b0;
    end else begin
      unique case (cur_r.st)
        ST_OFF: begin
          cur_nxt.tmr = `PKT_TIMER_ZERO;
          cur_nxt.run = freerun;
          cur_nxt.st = ST_WAIT;
        end
        ST_WAIT, ST_IDLE: begin
          if (q_start) begin
            cur_nxt.st = ST_REC;
            cur_nxt.run = 1'b1;
            cur_nxt.start = 1'b1;
            cur_nxt.serr = q_serr;
            cur_nxt.ierr = q_ierr && !word_ok_i;
          end
        end
        ST_REC: begin
          if (msg_end_i) begin
            cur_nxt.st = ST_IDLE;
          end
        end
      endcase
      if (pkt_final_i && cur_r.st != ST_OFF) begin
        cur_nxt.irq = irq_en_i;
        if (freerun) begin
          cur_nxt.tmr = `PKT_TIMER_ZERO;
          cur_nxt.run = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      cur_r <= '{cfg: `CFG_RESET, st: ST_OFF, tmr: `PKT_TIMER_ZERO, default: 1'b0};
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign cfg_rdata_o = cur_r.cfg;
  assign pkt_timer_o = cur_r.tmr;
  assign timer_run_o = cur_r.run;
  assign recording_o = (cur_r.st == ST_REC);
  assign msg_start_o = cur_r.start;
  assign sync_err_o = cur_r.serr;
  assign inv_err_o = cur_r.ierr;
  assign packet_done_irq_o = cur_r.irq;

  // ****************************************
  // Checks
  // ****************************************
  chk_hold_wait: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (cur_r.st == ST_WAIT && !freerun && !$past(q_start) && active) |-> pkt_timer_o == `PKT_TIMER_ZERO || timer_run_o)
    else $error("timer moved while waiting");
  chk_start_run: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (active && (cur_r.st == ST_WAIT) && q_start) |=> timer_run_o && recording_o)
    else $error("timer not started on qualifying word");
  chk_enable_free: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (active && cur_r.st == ST_OFF && freerun && !cfg_we_i) |=> timer_run_o && pkt_timer_o == `PKT_TIMER_ZERO)
    else $error("freerun timer did not start at enable");
  chk_final_restart: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (active && freerun && pkt_final_i && cur_r.st != ST_OFF) |=> pkt_timer_o == `PKT_TIMER_ZERO ##1
    pkt_timer_o == `PKT_TIMER_ONE)
    else $error("timer not restarted at finalize");
  chk_irq_pkt: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    packet_done_irq_o |-> $past(pkt_final_i) && $past(irq_en_i))
    else $error("interrupt without packet completion");
  chk_sel00_cmd: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (msg_start_o && $past(cur_r.cfg[6:5]) == `SRS_CMD_WORD) |-> $past(is_cmd_i && word_i && word_ok_i))
    else $error("select 00 started without valid command word");
  chk_sync_err: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (msg_start_o && $past(cur_r.cfg[5]) && !$past(is_cmd_i)) |-> sync_err_o)
    else $error("sync error missing on data sync start");
  chk_frag_start: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (msg_start_o && $past(cur_r.cfg[6])) |-> $past(sync2_i))
    else $error("fragment select started without sync");
  chk_inv_err: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    inv_err_o |-> msg_start_o && !$past(word_ok_i))
    else $error("invalid word flag without bad trigger");
  chk_type_sel: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    cur_r.cfg[0] |=> !recording_o)
    else $error("recording with simple monitor selected");
  cov_start: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) msg_start_o);
  cov_serr: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) sync_err_o);
  cov_ierr: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) inv_err_o);
  cov_irq: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) packet_done_irq_o);
endmodule : pkt_mon_ctrl

// File: pkt_mon_params.svh
// Register field positions, reset values and timing counts of the packet monitor control.
`ifndef PKT_MON_PARAMS_SVH
`define PKT_MON_PARAMS_SVH
`define CFG_RESET 16'h0000
`define CFG_BIT_TYPE_SEL 0
`define CFG_BIT_SRS_LO 5
`define CFG_BIT_SRS_HI 6
`define CFG_BIT_FREERUN 7
`define SRS_CMD_WORD 2'h0
`define SRS_ANY_WORD 2'h1
`define SRS_CMD_FRAG 2'h2
`define SRS_ANY_FRAG 2'h3
`define PKT_TIMER_W 32
`define PKT_TIMER_ONE 32'h0000_0001
`define PKT_TIMER_ZERO 32'h0000_0000
`endif

// File: pkt_mon_pkg.sv
// Types shared by the packet monitor control.
`include "pkt_mon_params.svh"
package pkt_mon_pkg;
  typedef enum logic [1:0] {
    ST_OFF = 2'h0,
    ST_WAIT = 2'h1,
    ST_REC = 2'h3,
    ST_IDLE = 2'h2
  } mon_state_t;
endpackage : pkt_mon_pkg

// File: start_qual.sv
// Start-record qualifier: decides whether a decoded pattern begins a message and its error flags.
`timescale 1ns/1ps
module start_qual
  import pkt_mon_pkg::*;
(
  // Selection.
  input wire logic [1:0] sel_i,
  // Decoder events.
  input wire logic sync2_i,
  input wire logic word_i,
  input wire logic is_cmd_i,
  input wire logic word_ok_i,
  // Result.
  output logic start_o,
  output logic sync_err_o,
  output logic inv_err_o
);
  always_comb begin
    start_o = 1'b0;
    sync_err_o = 1'b0;
    inv_err_o = 1'b0;
    unique case (sel_i)
      `SRS_CMD_WORD: begin
        start_o = word_i && word_ok_i && is_cmd_i;
      end
      `SRS_ANY_WORD: begin
        start_o = word_i && word_ok_i;
        sync_err_o = start_o && !is_cmd_i;
      end
      `SRS_CMD_FRAG: begin
        start_o = sync2_i && is_cmd_i;
        inv_err_o = start_o;
      end
      `SRS_ANY_FRAG: begin
        start_o = sync2_i;
        sync_err_o = start_o && !is_cmd_i;
        inv_err_o = start_o;
      end
    endcase
  end
endmodule : start_qual

// File: tb_top.sv
// Self-checking testbench of the packet monitor control.
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_i = 1'b0, nrst_i = 1'b0, cfg_we_i = 1'b0, mon_en_i = 1'b0, irq_en_i = 1'b0;
  logic msg_end_i = 1'b0, pkt_final_i = 1'b0;
  logic [15:0] cfg_wdata_i = 16'h0000, cfg_rdata_o;
  logic sync2, word, is_cmd, word_ok, timer_run_o, recording_o, msg_start_o, sync_err_o, inv_err_o, irq_o;
  logic [31:0] pkt_timer_o;
  logic [2:0] cap = 3'h0;
  logic cap_clr = 1'b0;
  int miscompares = 0, check_count = 0;
  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  bus_word_src bus_word_src_inst (.clk_sys_i(clk_sys_i), .sync2_o(sync2), .word_o(word), .is_cmd_o(is_cmd),
    .word_ok_o(word_ok));
  pkt_mon_ctrl pkt_mon_ctrl_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cfg_we_i(cfg_we_i),
    .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .mon_en_i(mon_en_i), .irq_en_i(irq_en_i),
    .sync2_i(sync2), .word_i(word), .is_cmd_i(is_cmd), .word_ok_i(word_ok), .msg_end_i(msg_end_i),
    .pkt_final_i(pkt_final_i), .pkt_timer_o(pkt_timer_o), .timer_run_o(timer_run_o),
    .recording_o(recording_o), .msg_start_o(msg_start_o), .sync_err_o(sync_err_o),
    .inv_err_o(inv_err_o), .packet_done_irq_o(irq_o));
  // Latches the start pulse and its flags for a later comparison.
  always @(posedge clk_sys_i) begin
    if (cap_clr) cap <= 3'h0;
    else if (msg_start_o === 1'b1) cap <= {1'b1, sync_err_o, inv_err_o};
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  function automatic logic [2:0] expv(input logic [1:0] s, input logic c, input logic o, input logic f);
    logic st;
    st = s[1] ? (c | s[0]) : (f & o & (c | s[0]));
    return {st, st & !c, st & s[1] & !o};
  endfunction : expv
  task automatic wcfg(input logic [15:0] v);
    @(negedge clk_sys_i);
    cfg_we_i = 1'b1;
    cfg_wdata_i = v;
    @(negedge clk_sys_i);
    cfg_we_i = 1'b0;
    check(cfg_rdata_o, v);
  endtask : wcfg
  task automatic ev(input logic [1:0] s, input logic c, input logic o, input logic f, input logic act);
    cap_clr = 1'b1;
    @(negedge clk_sys_i);
    cap_clr = 1'b0;
    bus_word_src_inst.send(c, o, f);
    repeat (2) @(negedge clk_sys_i);
    check(cap, act ? expv(s, c, o, f) : 3'h0);
  endtask : ev
  task automatic pulse_end();
    @(negedge clk_sys_i);
    msg_end_i = 1'b1;
    @(negedge clk_sys_i);
    msg_end_i = 1'b0;
    @(negedge clk_sys_i);
    check(recording_o, 1'b0);
  endtask : pulse_end
  initial begin
    #100000;
    miscompares++;
    final_report();
  end
  initial begin
    logic [2:0] r;
    void'($urandom(32'h0772a2af));
    repeat (2) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    wcfg(16'($urandom()) & 16'hff9e);
    for (int s = 0; s < 4; s++) begin
      wcfg({8'h00, 1'b0, 2'(s), 5'h00});
      mon_en_i = 1'b1;
      repeat (2) @(negedge clk_sys_i);
      if (s == 0) begin
        check(pkt_timer_o, 32'h0000_0000);
        check(32'(timer_run_o), 32'h0000_0000);
        ev(2'(s), 1'b1, 1'b1, 1'b1, 1'b1);
        check(timer_run_o, 1'b1);
        ev(2'(s), 1'b1, 1'b1, 1'b1, 1'b0);
        pulse_end();
      end
      for (int k = 0; k < 8; k++) begin
        r = 3'($urandom());
        ev(2'(s), r[0], r[1], r[2] | (k == 0), 1'b1);
        pulse_end();
      end
    end
    wcfg(16'h0001);
    ev(2'h0, 1'b1, 1'b1, 1'b1, 1'b0);
    mon_en_i = 1'b0;
    wcfg(16'h0080);
    irq_en_i = 1'b1;
    mon_en_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    check(timer_run_o, 1'b1);
    repeat (5) @(negedge clk_sys_i);
    pkt_final_i = 1'b1;
    @(negedge clk_sys_i);
    pkt_final_i = 1'b0;
    check(irq_o, 1'b1);
    check(pkt_timer_o < 32'd3, 1'b1);
    final_report();
  end
endmodule : tb_top
